// [core/frsc_divider.sv]
// Sequential restoring divider for the ramp increment
`timescale 1ns/1ps
`default_nettype none
module frsc_divider (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_reset,
  input  wire logic                    i_start,
  input  wire frsc_pkg::frsc_div_req_t i_req,
  output var  frsc_pkg::frsc_div_rsp_t o_rsp
);
  typedef struct packed {
    logic [31:0] quot;
    logic [24:0] rem;
    logic [23:0] dvs;
    logic [4:0]  cnt;
    logic        busy;
    logic        done;
  } frsc_div_state_t;

  frsc_div_state_t st_reg;
  frsc_div_state_t st_next;
  logic [24:0]     trial;

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    trial        = {st_reg.rem[23:0], st_reg.quot[31]};
    if (!st_reg.busy) begin
      if (i_start) begin
        st_next.busy = 1'b1;
        st_next.cnt  = 5'h00;
        st_next.quot = i_req.dividend;
        st_next.rem  = 25'h0;
        st_next.dvs  = i_req.divisor;
      end
    end else begin
      if (trial >= {1'b0, st_reg.dvs}) begin
        st_next.rem  = trial - {1'b0, st_reg.dvs};
        st_next.quot = {st_reg.quot[30:0], 1'b1};
      end else begin
        st_next.rem  = trial;
        st_next.quot = {st_reg.quot[30:0], 1'b0};
      end
      st_next.cnt = st_reg.cnt + 5'h01;
      if (st_reg.cnt == 5'h1F) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rsp = '{quotient: st_reg.quot, done: st_reg.done, busy: st_reg.busy};

  a_div_latency: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_start && !o_rsp.busy) |-> ##33 o_rsp.done)
    else $error("divider result late or early");
endmodule : frsc_divider
`default_nettype wire

// [core/frsc_pkg.sv]
// Constants and carrier types of the frequency ramp and start control
package frsc_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned TICK_PERIOD_NS = 10000000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TERM   = 8'h04;
  localparam logic [7:0] OFS_MAXF   = 8'h08;
  localparam logic [7:0] OFS_TGT    = 8'h0C;
  localparam logic [7:0] OFS_SCURVE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_TIMES  = 8'h40;

  // Control register fields
  localparam int unsigned CTRL_AUTO     = 0;
  localparam int unsigned CTRL_RESTART  = 1;
  localparam int unsigned CTRL_SRC_LSB  = 2;
  localparam int unsigned CTRL_REF      = 4;
  localparam int unsigned CTRL_UNIT_LSB = 5;
  localparam int unsigned CTRL_APROF    = 7;
  localparam int unsigned CTRL_DPROF    = 8;

  // Terminal code and S-curve fields
  localparam int unsigned TERM3_LSB    = 0;
  localparam int unsigned TERM4_LSB    = 8;
  localparam int unsigned TERM5_LSB    = 16;
  localparam int unsigned SC_START_LSB = 0;
  localparam int unsigned SC_END_LSB   = 8;

  // Reset values
  localparam logic [15:0] CTRL_RST      = 16'h0024;
  localparam logic [23:0] TERM_RST      = 24'h040302;
  localparam logic [15:0] MAXF_RST      = 16'h1770;
  localparam logic [15:0] SCURVE_RST    = 16'h2828;
  localparam logic [15:0] BASE_ACC_RST  = 16'h0032;
  localparam logic [15:0] BASE_DEC_RST  = 16'h0064;
  localparam logic [15:0] MULTI_ACC_RST = 16'h001E;
  localparam logic [15:0] MULTI_DEC_RST = 16'h005A;

  // Limits and codes
  localparam logic [15:0] TIME_MAX      = 16'hEA60;
  localparam logic [15:0] MAXF_MAX      = 16'h9C40;
  localparam logic [7:0]  TERM_CODE_MAX = 8'h18;
  localparam logic [6:0]  PCT_MIN       = 7'h01;
  localparam logic [6:0]  PCT_MAX       = 7'h64;
  localparam logic [1:0]  SRC_TERM1     = 2'h1;
  localparam logic [1:0]  SRC_TERM2     = 2'h2;
  localparam logic [7:0]  FUNC_RAMP_B0  = 8'h08;
  localparam logic [7:0]  FUNC_RAMP_B1  = 8'h09;
  localparam logic [7:0]  FUNC_RAMP_B2  = 8'h0A;
  localparam logic [6:0]  UNIT_MULT0    = 7'h01;
  localparam logic [6:0]  UNIT_MULT1    = 7'h0A;
  localparam logic [6:0]  UNIT_MULT2    = 7'h64;

  typedef struct packed {
    logic [31:0] dividend;
    logic [23:0] divisor;
  } frsc_div_req_t;

  typedef struct packed {
    logic [31:0] quotient;
    logic        done;
    logic        busy;
  } frsc_div_rsp_t;
endpackage : frsc_pkg

// [core/frsc_ramp_ctrl.sv]
// Frequency ramp generator with power-on and fault-reset auto-start
// Behaviour
// - Power-on with terminal run on starts ramp
// - Keypad source ignores power-on auto-start
// - Fault clear with terminal on restarts
// - Keypad source ignores restart after fault
// - Reference 0: time covers zero to maximum
// - Slope is maximum over time, maximum 400 Hz
// - Separate base times, default 5.0/10.0 s
// - Unit code scales time: 0.01/0.1/1 s
// - Reference 1: time covers present to target
// - New target replanned over same preset time
// - All select terminals off: base times
// - Index weights 4, 2, 1 pick stored pair
// - S-curve portions 1 to 100, default 40
// - Accel and decel profiles chosen separately
// - S-curve may stretch the real ramp time
`timescale 1ns/1ps
`default_nettype none
module frsc_ramp_ctrl #(
  parameter int unsigned P_TICK_CYCLES = frsc_pkg::TICK_CYCLES
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output var  logic [31:0] o_avs_readdata,
  output var  logic        o_avs_waitrequest,
  input  wire logic        i_ac_power_ok,
  input  wire logic        i_fault,
  input  wire logic        i_run_term,
  input  wire logic        i_key_run,
  input  wire logic        i_key_stop,
  input  wire logic        i_ramp_select_bit0_input,
  input  wire logic        i_ramp_select_bit1_input,
  input  wire logic        i_ramp_select_bit2_input,
  output var  logic [15:0] o_freq_cmd,
  output var  logic        o_running,
  output var  logic        o_ramping
);
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_DIV  = 3'b010,
    ST_RAMP = 3'b100
  } frsc_ramp_state_t;

  typedef struct packed {
    logic              waitreq;
    logic [31:0]       rdata;
    logic [15:0]       ctrl;
    logic [23:0]       term;
    logic [15:0]       maxf;
    logic [15:0]       tgt;
    logic [15:0]       scurve;
    logic [15:0][15:0] times;
    logic              run;
    logic              pwr_q;
    logic              fault_q;
    logic              term_q;
    logic [31:0]       tick_cnt;
    frsc_ramp_state_t  state;
    logic              ramping;
    logic [31:0]       acc;
    logic [31:0]       inc;
    logic [15:0]       from;
    logic [15:0]       dest;
    logic [15:0]       span;
    logic [23:0]       denom;
    logic              up;
    logic [2:0]        idx;
    logic              div_go;
  } frsc_state_t;

  localparam logic [15:0][15:0] TIMES_RST = {{7{frsc_pkg::MULTI_DEC_RST, frsc_pkg::MULTI_ACC_RST}},
                                             frsc_pkg::BASE_DEC_RST, frsc_pkg::BASE_ACC_RST};
  // Auto-start bits clear in CTRL_RST
  localparam frsc_state_t ST_RST = '{waitreq: 1'b1, ctrl: frsc_pkg::CTRL_RST, term: frsc_pkg::TERM_RST,
                                     maxf: frsc_pkg::MAXF_RST, scurve: frsc_pkg::SCURVE_RST,
                                     times: TIMES_RST, state: ST_HOLD, default: '0};

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      be_merge[8*b +: 8] = be[b] ? wd[8*b +: 8] : old[8*b +: 8];
    end
  endfunction : be_merge

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp16

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? (a - b) : (b - a);
  endfunction : absdiff

  // Part of a move lies inside a percentage of its total
  function automatic logic in_zone(input logic [15:0] part, input logic [15:0] total,
                                   input logic [6:0] pct);
    in_zone = (23'(part) * 23'(frsc_pkg::PCT_MAX)) < (23'(total) * 23'(pct));
  endfunction : in_zone

  function automatic logic [6:0] unit_mult(input logic [1:0] code);
    case (code)
      2'h0:    unit_mult = frsc_pkg::UNIT_MULT0;
      2'h1:    unit_mult = frsc_pkg::UNIT_MULT1;
      default: unit_mult = frsc_pkg::UNIT_MULT2;
    endcase
  endfunction : unit_mult

  function automatic logic [7:0] code_lim(input logic [7:0] v);
    code_lim = (v > frsc_pkg::TERM_CODE_MAX) ? frsc_pkg::TERM_CODE_MAX : v;
  endfunction : code_lim

  frsc_state_t             st;
  frsc_state_t             n;
  frsc_pkg::frsc_div_req_t div_req;
  frsc_pkg::frsc_div_rsp_t div_rsp;
  logic [5:0]              widx;
  logic [31:0]             rd_val;
  logic [31:0]             wmerged;
  logic [1:0]              src;
  logic                    term_mode;
  logic                    ref_delta;
  logic [2:0]              ramp_idx;
  logic [15:0]             freq;
  logic [15:0]             tgt_eff;
  logic [15:0]             sel_time;
  logic [15:0]             total;
  logic                    tick;
  logic                    s_on;
  logic                    s_zone;
  logic [31:0]             step;
  logic [31:0]             dest_fx;
  logic [32:0]             sum;

  assign widx      = i_avs_address[7:2];
  assign src       = st.ctrl[frsc_pkg::CTRL_SRC_LSB +: 2];
  assign term_mode = (src == frsc_pkg::SRC_TERM1) || (src == frsc_pkg::SRC_TERM2);
  assign ref_delta = st.ctrl[frsc_pkg::CTRL_REF];
  assign freq      = st.acc[31:16];
  assign tick      = st.tick_cnt == 32'(P_TICK_CYCLES - 1);
  assign dest_fx   = {st.dest, 16'h0000};
  assign total     = absdiff(st.dest, st.from);

  // Terminal only counts when its function code selects ramp time
  assign ramp_idx = {i_ramp_select_bit2_input && st.term[frsc_pkg::TERM5_LSB +: 8] == frsc_pkg::FUNC_RAMP_B2,
                     i_ramp_select_bit1_input && st.term[frsc_pkg::TERM4_LSB +: 8] == frsc_pkg::FUNC_RAMP_B1,
                     i_ramp_select_bit0_input && st.term[frsc_pkg::TERM3_LSB +: 8] == frsc_pkg::FUNC_RAMP_B0};

  assign tgt_eff = !st.run ? 16'h0000 : ((st.tgt > st.maxf) ? st.maxf : st.tgt);

  // Even slot accel, odd slot decel of each index
  assign sel_time = (tgt_eff > freq) ? st.times[{ramp_idx, 1'b0}] : st.times[{ramp_idx, 1'b1}];

  assign s_on = st.up ? st.ctrl[frsc_pkg::CTRL_APROF] : st.ctrl[frsc_pkg::CTRL_DPROF];
  assign s_zone = s_on && (in_zone(absdiff(freq, st.from), total, st.scurve[frsc_pkg::SC_START_LSB +: 7]) ||
                           in_zone(absdiff(st.dest, freq), total, st.scurve[frsc_pkg::SC_END_LSB +: 7]));
  // Half slope inside the S portions stretches the ramp
  assign step = (s_zone && st.inc > 32'h1) ? {1'b0, st.inc[31:1]} : st.inc;

  assign div_req = '{dividend: {st.span, 16'h0000}, divisor: st.denom};

  always_comb begin
    case (widx)
      frsc_pkg::OFS_CTRL[7:2]:   rd_val = {16'h0000, st.ctrl};
      frsc_pkg::OFS_TERM[7:2]:   rd_val = {8'h00, st.term};
      frsc_pkg::OFS_MAXF[7:2]:   rd_val = {16'h0000, st.maxf};
      frsc_pkg::OFS_TGT[7:2]:    rd_val = {16'h0000, st.tgt};
      frsc_pkg::OFS_SCURVE[7:2]: rd_val = {16'h0000, st.scurve};
      frsc_pkg::OFS_STATUS[7:2]: rd_val = {11'h000, st.idx, st.ramping, st.run, freq};
      default: begin
        if (widx[5:4] == frsc_pkg::OFS_TIMES[7:6]) begin
          rd_val = {16'h0000, st.times[widx[3:0]]};
        end else begin
          rd_val = 32'h0000_0000;
        end
      end
    endcase
  end

  assign wmerged = be_merge(rd_val, i_avs_writedata, i_avs_byteenable);

  always_comb begin
    n = st;
    sum = 33'h0;
    // Bus: one wait cycle, write acts on the edge waitrequest is low
    n.waitreq = !((i_avs_read || i_avs_write) && st.waitreq);
    n.rdata   = rd_val;
    if (i_avs_write && !st.waitreq) begin
      case (widx)
        frsc_pkg::OFS_CTRL[7:2]:   n.ctrl = {7'h00, wmerged[8:0]};
        frsc_pkg::OFS_TERM[7:2]:   n.term = {code_lim(wmerged[23:16]), code_lim(wmerged[15:8]),
                                             code_lim(wmerged[7:0])};
        frsc_pkg::OFS_MAXF[7:2]:   n.maxf = clamp16(wmerged[15:0], 16'h0000, frsc_pkg::MAXF_MAX);
        frsc_pkg::OFS_TGT[7:2]:    n.tgt = clamp16(wmerged[15:0], 16'h0000, frsc_pkg::MAXF_MAX);
        frsc_pkg::OFS_SCURVE[7:2]: n.scurve = {1'b0, 7'(clamp16({9'h000, wmerged[14:8]}, 16'(frsc_pkg::PCT_MIN),
                                                 16'(frsc_pkg::PCT_MAX))),
                                             1'b0, 7'(clamp16({9'h000, wmerged[6:0]}, 16'(frsc_pkg::PCT_MIN),
                                                 16'(frsc_pkg::PCT_MAX)))};
        default: begin
          if (widx[5:4] == frsc_pkg::OFS_TIMES[7:6]) begin
            n.times[widx[3:0]] = clamp16(wmerged[15:0], 16'h0000, frsc_pkg::TIME_MAX);
          end
        end
      endcase
    end

    // Run request
    n.pwr_q   = i_ac_power_ok;
    n.fault_q = i_fault;
    n.term_q  = i_run_term;
    if (i_fault || !i_ac_power_ok) begin
      n.run = 1'b0;
    end else if (term_mode) begin
      if (!i_run_term) begin
        n.run = 1'b0;
      end else if (!st.term_q) begin
        n.run = 1'b1;
      end else if (!st.pwr_q && st.ctrl[frsc_pkg::CTRL_AUTO]) begin
        n.run = 1'b1;
      end else if (st.fault_q && st.ctrl[frsc_pkg::CTRL_RESTART]) begin
        n.run = 1'b1;
      end
    end else if (i_key_stop) begin
      n.run = 1'b0;
    end else if (i_key_run) begin
      n.run = 1'b1;
    end

    n.tick_cnt = tick ? 32'h0 : st.tick_cnt + 32'h1;
    n.div_go   = 1'b0;
    case (st.state)
      ST_HOLD: begin
        if (freq != tgt_eff) begin
          n.from  = freq;
          n.dest  = tgt_eff;
          n.up    = tgt_eff > freq;
          n.idx   = ramp_idx;
          n.span  = ref_delta ? absdiff(tgt_eff, freq) : st.maxf;
          n.denom = 24'({8'h00, sel_time} * {17'h00000, unit_mult(st.ctrl[frsc_pkg::CTRL_UNIT_LSB +: 2])});
          if (n.denom == 24'h0) begin
            n.acc = {tgt_eff, 16'h0000};
          end else begin
            n.state  = ST_DIV;
            n.div_go = 1'b1;
          end
        end
      end
      ST_DIV: begin
        if (div_rsp.done) begin
          n.inc   = (div_rsp.quotient == 32'h0) ? 32'h1 : div_rsp.quotient;
          n.state = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (tgt_eff != st.dest) begin
          n.state = ST_HOLD;
        end else if (tick) begin
          if (st.up) begin
            sum = {1'b0, st.acc} + {1'b0, step};
            if (sum >= {1'b0, dest_fx}) begin
              n.acc   = dest_fx;
              n.state = ST_HOLD;
            end else begin
              n.acc = sum[31:0];
            end
          end else begin
            sum = {1'b0, dest_fx} + {1'b0, step};
            if ({1'b0, st.acc} <= sum) begin
              n.acc   = dest_fx;
              n.state = ST_HOLD;
            end else begin
              n.acc = st.acc - step;
            end
          end
        end
      end
      default: n.state = ST_HOLD;
    endcase

    if (i_fault) begin
      n.acc = 32'h0;
      if (st.state == ST_RAMP) begin
        n.state = ST_HOLD;
      end
    end
    n.ramping = n.state != ST_HOLD;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st <= ST_RST;
    end else begin
      st <= n;
    end
  end

  frsc_divider u_divider (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_start   (st.div_go),
    .i_req     (div_req),
    .o_rsp     (div_rsp)
  );

  assign o_avs_readdata    = st.rdata;
  assign o_avs_waitrequest = st.waitreq;
  assign o_freq_cmd        = freq;
  assign o_running         = st.run;
  assign o_ramping         = st.ramping;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  a_power_autostart: assert property (
    ($rose(i_ac_power_ok) && st.ctrl[frsc_pkg::CTRL_AUTO] && term_mode && i_run_term && $past(i_run_term)
     && !i_fault) |=> o_running)
    else $error("no auto-start at power application");
  a_keypad_hold: assert property (
    (!term_mode && !st.run && !i_key_run) |=> !o_running)
    else $error("keypad source started without run key");
  a_fault_restart: assert property (
    ($fell(i_fault) && st.ctrl[frsc_pkg::CTRL_RESTART] && term_mode && i_run_term && i_ac_power_ok)
    |=> o_running)
    else $error("no restart after fault clear");
  a_restart_off: assert property (
    ($fell(i_fault) && !st.ctrl[frsc_pkg::CTRL_RESTART] && term_mode && $past(i_run_term) && i_run_term
     && $stable(i_ac_power_ok)) |=> !o_running)
    else $error("restart without enable");
  a_reset_defaults: assert property (@(posedge i_ref_clk) disable iff (1'b0)
    i_reset |=> (!st.ctrl[frsc_pkg::CTRL_AUTO] && !st.ctrl[frsc_pkg::CTRL_RESTART]))
    else $error("auto-start enabled after reset");
  a_span_max: assert property (
    (st.state == ST_DIV && $past(st.state) == ST_HOLD && !$past(ref_delta)) |-> st.span == $past(st.maxf))
    else $error("span is not maximum frequency");
  a_span_delta: assert property (
    (st.state == ST_DIV && $past(st.state) == ST_HOLD && $past(ref_delta)) |-> st.span == total)
    else $error("span is not frequency difference");
  a_index_weight: assert property (
    (i_ramp_select_bit2_input && !i_ramp_select_bit1_input && i_ramp_select_bit0_input
     && st.term == {frsc_pkg::FUNC_RAMP_B2, frsc_pkg::FUNC_RAMP_B1, frsc_pkg::FUNC_RAMP_B0}) |-> ramp_idx == 3'h5)
    else $error("ramp index weighting wrong");
  a_index_zero: assert property (
    (!i_ramp_select_bit0_input && !i_ramp_select_bit1_input && !i_ramp_select_bit2_input) |-> ramp_idx == 3'h0)
    else $error("ramp index not zero");
  a_time_range: assert property (
    st.times[0] <= frsc_pkg::TIME_MAX && st.times[1] <= frsc_pkg::TIME_MAX
    && st.scurve[6:0] >= frsc_pkg::PCT_MIN && st.scurve[6:0] <= frsc_pkg::PCT_MAX)
    else $error("setting out of range");
  a_ramp_step: assert property (
    (st.state == ST_RAMP && tick && st.up && !i_fault && tgt_eff == st.dest && !s_zone)
    |=> (st.acc > $past(st.acc)) && (st.acc - $past(st.acc) <= $past(st.inc)))
    else $error("ramp step not one increment");
  a_scurve_slow: assert property (
    (st.state == ST_RAMP && tick && st.up && !i_fault && tgt_eff == st.dest && s_zone && st.inc > 32'h1)
    |=> (st.acc - $past(st.acc)) <= ($past(st.inc) >> 1))
    else $error("S-curve portion not slowed");
  a_fault_stop: assert property (
    i_fault |=> (o_freq_cmd == 16'h0000 && !o_running))
    else $error("fault did not stop output");

  c_autostart: cover property ($rose(i_ac_power_ok) ##1 o_running);
  c_restart: cover property ($fell(i_fault) ##1 o_running);
  c_ramp_done: cover property (st.state == ST_RAMP ##1 st.state == ST_HOLD);
  c_scurve: cover property (st.state == ST_RAMP && s_zone && tick);
endmodule : frsc_ramp_ctrl
`default_nettype wire

// [testbench/frsc_motor_model.sv]
// Motor stage model that tracks the largest step of the frequency command
`timescale 1ns/1ps
`default_nettype none
module frsc_motor_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_clear,
  input  wire logic [15:0] i_freq_cmd,
  output var  logic [15:0] o_max_step
);
  logic [15:0] last_reg;
  logic [15:0] diff;

  assign diff = (i_freq_cmd > last_reg) ? i_freq_cmd - last_reg : last_reg - i_freq_cmd;

  always_ff @(posedge i_ref_clk) begin
    last_reg <= i_freq_cmd;
    if (i_clear) begin
      o_max_step <= 16'h0000;
    end else if (diff > o_max_step) begin
      o_max_step <= diff;
    end
  end
endmodule : frsc_motor_model
`default_nettype wire

// [testbench/frsc_ramp_ctrl_tb.sv]
// Self-checking bench of the ramp and start control
`timescale 1ns/1ps
`default_nettype none
module frsc_ramp_ctrl_tb;
  localparam int P = 40;
  logic        clk, rst, rd, wr, pwr, flt, run, krun, kstop, s0, s1, s2, clr;
  logic [7:0]  adr;
  logic [31:0] wd, rdata, q;
  logic        waitreq, running, ramping;
  logic [15:0] freq, step;
  int          miscompares = 0;
  int          check_count = 0;
  int          n;

  frsc_ramp_ctrl #(.P_TICK_CYCLES(P)) uut (.i_ref_clk(clk), .i_reset(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_ac_power_ok(pwr), .i_fault(flt),
    .i_run_term(run), .i_key_run(krun), .i_key_stop(kstop), .i_ramp_select_bit0_input(s0),
    .i_ramp_select_bit1_input(s1), .i_ramp_select_bit2_input(s2), .o_freq_cmd(freq),
    .o_running(running), .o_ramping(ramping));
  frsc_motor_model partner (.i_ref_clk(clk), .i_clear(clr), .i_freq_cmd(freq), .o_max_step(step));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task finish_test;
    $display("mismatches %0d, checks %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task fail_out;
    miscompares++;
    $display("unexpected at %0t: wait ran out", $time);
    finish_test();
  endtask : fail_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k == 20) fail_out();
    @(posedge clk);
  endtask : bus

  task wait_cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : wait_cyc

  // Write a target, time the ramp in cycles and check the slope
  task ramp_to(input logic [15:0] tgt, input int lo, input int hi, input logic [15:0] inc);
    clr <= 1'b1;
    bus(1'b1, 8'h0C, {16'h0000, tgt});
    clr <= 1'b0;
    wait_cyc(2);
    chk({31'h0, ramping}, 32'h1);
    for (n = 0; n < 2000 && freq !== tgt; n++) @(posedge clk);
    if (n == 2000) fail_out();
    chk({31'h0, ramping}, 32'h0);
    chk(32'(n >= lo && n <= hi), 32'h1);
    chk({16'h0000, step}, {16'h0000, inc});
  endtask : ramp_to

  task reset_regs;
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_0024);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0000_0032);
    bus(1'b0, 8'h44, 32'h0);
    chk(q, 32'h0000_0064);
    bus(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0000_2828);
    bus(1'b1, 8'h10, 32'h0000_6500);
    bus(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0000_6401);
    bus(1'b1, 8'h40, 32'h0000_FFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0000_EA60);
    bus(1'b0, 8'hFC, 32'h0);
    chk(q, 32'h0000_0000);
  endtask : reset_regs

  task keypad_auto;
    bus(1'b1, 8'h00, 32'h0000_0003);
    run <= 1'b1;
    pwr <= 1'b1;
    wait_cyc(4);
    chk({31'h0, running}, 32'h0);
    flt <= 1'b1;
    wait_cyc(2);
    flt <= 1'b0;
    wait_cyc(4);
    chk({31'h0, running}, 32'h0);
    krun <= 1'b1;
    wait_cyc(1);
    krun <= 1'b0;
    wait_cyc(2);
    chk({31'h0, running}, 32'h1);
    kstop <= 1'b1;
    wait_cyc(1);
    kstop <= 1'b0;
    wait_cyc(2);
    chk({31'h0, running}, 32'h0);
  endtask : keypad_auto

  task term_auto;
    pwr <= 1'b0;
    bus(1'b1, 8'h00, 32'h0000_0007);
    wait_cyc(2);
    pwr <= 1'b1;
    wait_cyc(3);
    chk({31'h0, running}, 32'h1);
    flt <= 1'b1;
    wait_cyc(3);
    chk({31'h0, running}, 32'h0);
    flt <= 1'b0;
    wait_cyc(3);
    chk({31'h0, running}, 32'h1);
    bus(1'b1, 8'h00, 32'h0000_0004);
    flt <= 1'b1;
    wait_cyc(2);
    flt <= 1'b0;
    wait_cyc(3);
    chk({31'h0, running}, 32'h0);
    run <= 1'b0;
    wait_cyc(2);
    run <= 1'b1;
    wait_cyc(3);
    chk({31'h0, running}, 32'h1);
  endtask : term_auto

  task ramps;
    bus(1'b1, 8'h40, 32'h0000_0004);
    ramp_to(16'h0BB8, P, 3 * P + 40, 16'h05DC);
    bus(1'b1, 8'h00, 32'h0000_0017);
    ramp_to(16'h1194, 3 * P, 5 * P + 40, 16'h0177);
    bus(1'b1, 8'h04, 32'h000A_0908);
    s0 <= 1'b1;
    s2 <= 1'b1;
    bus(1'b1, 8'h68, 32'h0000_0008);
    ramp_to(16'h1770, 7 * P, 9 * P + 40, 16'h00BC);
    bus(1'b0, 8'h14, 32'h0);
    chk({29'h0, q[20:18]}, 32'h5);
    bus(1'b1, 8'h00, 32'h0000_0037);
    bus(1'b1, 8'h6C, 32'h0000_0001);
    ramp_to(16'h1194, 9 * P, 11 * P + 40, 16'h0096);
    bus(1'b1, 8'h00, 32'h0000_0097);
    ramp_to(16'h1770, 15 * P, 17 * P + 40, 16'h005E);
    bus(1'b1, 8'h08, 32'h0000_FFFF);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0000_9C40);
  endtask : ramps

  initial begin
    rst = 1'b1;
    {rd, wr, pwr, flt, run, krun, kstop, s0, s1, s2, clr} = '0;
    adr = 8'h00;
    wd = 32'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reset_regs();
    keypad_auto();
    term_auto();
    ramps();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_out();
  end
endmodule : frsc_ramp_ctrl_tb
`default_nettype wire
